// ===== tmc_pkg.sv
`default_nettype none
package tmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_T0LO = 8'h08;
  localparam logic [7:0] OFS_T0HI = 8'h0C;
  localparam logic [7:0] OFS_T1LO = 8'h10;
  localparam logic [7:0] OFS_T1HI = 8'h14;
  localparam logic [7:0] OFS_T2CTRL = 8'h18;
  localparam logic [7:0] OFS_T2LO = 8'h1C;
  localparam logic [7:0] OFS_T2HI = 8'h20;
  localparam logic [7:0] OFS_RELLO = 8'h24;
  localparam logic [7:0] OFS_RELHI = 8'h28;
  localparam logic [7:0] OFS_T2OPT = 8'h2C;
  localparam logic [7:0] OFS_CLKSEL = 8'h30;
  // timer mode register: per-timer nibble, timer 1 in the upper one
  localparam int T1_NIB = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_CT = 2;
  // control register
  localparam int CTRL_T1OVF = 7;
  localparam int CTRL_T1RUN = 6;
  localparam int CTRL_T0OVF = 5;
  localparam int CTRL_T0RUN = 4;
  // timer 2 control register
  localparam int T2_OVF = 7;
  localparam int T2_EXTF = 6;
  localparam int T2_RXSRC = 5;
  localparam int T2_TXSRC = 4;
  localparam int T2_EXTEN = 3;
  localparam int T2_RUN = 2;
  localparam int T2_CSRC = 1;
  localparam int T2_CPRL = 0;
  localparam int OPT_CLKOE = 0;
  localparam int CLKSEL_FAST = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // device clocks per count
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} tmc_mode_e;
endpackage : tmc_pkg
`default_nettype wire

// ===== tmc_t2_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmc_t2_if;
  logic preTick;
  logic run;
  logic baudMode;
  logic clkOutMode;
  logic trigEn;
  logic trigPin;
  logic [15:0] reload;
  logic wrLo;
  logic wrHi;
  logic [7:0] wrData;
  logic [15:0] count;
  logic setOvf;
  logic setExtFlag;
  logic clkOut;
  modport ctrl (output preTick, run, baudMode, clkOutMode, trigEn, trigPin, reload, wrLo,
    wrHi, wrData, input count, setOvf, setExtFlag, clkOut);
  modport unit (input preTick, run, baudMode, clkOutMode, trigEn, trigPin, reload, wrLo,
    wrHi, wrData, output count, setOvf, setExtFlag, clkOut);
endinterface : tmc_t2_if
`default_nettype wire

// ===== tmc_timer2.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_timer2 (
  input wire logic clk,
  input wire logic rst,
  tmc_t2_if.unit t2
);
  logic div2, next_div2;
  logic trigPrev, next_trigPrev;
  logic [15:0] count, next_count;
  logic setOvf, next_setOvf;
  logic setExtFlag, next_setExtFlag;
  logic clkOut, next_clkOut;
  logic fastMode, tick, roll, trigFall;

  always_comb
  begin
    fastMode = t2.baudMode | t2.clkOutMode;
    // both fast modes step every 2 clocks whatever the count source select says
    tick = fastMode ? div2 : t2.preTick;
    roll = t2.run && tick && (count == tmc_pkg::CNT_TOP);
    trigFall = trigPrev & ~t2.trigPin;
    next_div2 = ~div2;
    next_trigPrev = t2.trigPin;
    next_count = count;
    if (t2.run && tick)
    begin
      next_count = roll ? t2.reload : count + 16'h0001;
    end
    if (t2.wrLo)
    begin
      next_count[7:0] = t2.wrData;
    end
    if (t2.wrHi)
    begin
      next_count[15:8] = t2.wrData;
    end
    next_setOvf = roll && !fastMode;
    next_setExtFlag = trigFall && t2.trigEn;
    // toggling per rollover gives 50% duty at clock / (4 x reload span)
    next_clkOut = (roll && t2.clkOutMode) ? ~clkOut : clkOut;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div2 <= 1'b0;
      trigPrev <= 1'b1;
      count <= 16'h0000;
      setOvf <= 1'b0;
      setExtFlag <= 1'b0;
      clkOut <= 1'b0;
    end
    else
    begin
      div2 <= next_div2;
      trigPrev <= next_trigPrev;
      count <= next_count;
      setOvf <= next_setOvf;
      setExtFlag <= next_setExtFlag;
      clkOut <= next_clkOut;
    end
  end

  assign t2.count = count;
  assign t2.setOvf = setOvf;
  assign t2.setExtFlag = setExtFlag;
  assign t2.clkOut = clkOut;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // the step lands one edge later, so baud mode and run must still hold then
  AST_T2_BAUD_RATE: assert property ((t2.baudMode && t2.run && !div2 && !t2.wrLo && !t2.wrHi
    && count < 16'hFFFE) ##1 (t2.baudMode && t2.run && !t2.wrLo && !t2.wrHi)
    |=> count == $past(count, 2) + 16'h0001)
    else $error("baud mode timer 2 not stepping every 2 clocks");
  AST_T2_RELOAD: assert property (roll && fastMode && !t2.wrLo && !t2.wrHi
    |=> count == $past(t2.reload))
    else $error("timer 2 did not reload on rollover");
  AST_T2_NO_FLAG: assert property (roll && fastMode |=> !setOvf)
    else $error("timer 2 overflow flagged in baud or clock-out mode");
  AST_T2_CLKOUT: assert property (roll && t2.clkOutMode |=> clkOut != $past(clkOut))
    else $error("clock-out did not toggle on rollover");
  AST_T2_TRIGGER: assert property (trigPrev && !t2.trigPin && t2.trigEn |=> setExtFlag)
    else $error("trigger falling edge not flagged");
  AST_T2_HOLD: assert property (!t2.run && !t2.wrLo && !t2.wrHi |=> $stable(count))
    else $error("timer 2 moved while stopped");
  COV_T2_CLKOUT: cover property (roll && t2.clkOutMode && t2.baudMode);
  COV_T2_TRIGGER: cover property (setExtFlag);
endmodule : tmc_timer2
`default_nettype wire

// ===== tmc_timer_top.sv
// Overview of operation
// - Timer 1 in mode 3 holds its count frozen.
// - Timer 0 mode 3 splits its low and high bytes into two 8-bit counters.
// - Timer 0 low byte uses timer 0 select, gate, run, pin and flag.
// - Timer 0 low byte counts clock/12 or /4, or count-input falling edges.
// - Timer 0 high byte counts clock/12 or /4, runs on timer 1 run bit, sets timer 1 flag.
// - Timer 1 keeps modes 0-2 but loses its flag and run bit.
// - Timer 1 still honours gate and pin one, and feeds the baud clock.
// - Timer 1 runs out of mode 3 and freezes in mode 3.
// - Either baud source bit puts timer 2 in baud-rate-generator mode.
// - Baud mode: 16-bit up counter reloading on rollover from all ones.
// - Baud-mode rollover leaves the timer 2 overflow flag alone.
// - Trigger enabled: trigger pin falling edge sets trigger flag, requests interrupt.
// - Clock-out mode drives a 50% duty square wave on port 1 bit 0.
// - Timer 2 counts only while its run bit is set.
// - Clock-out mode raises no interrupt on timer 2 overflow.
// - Baud and clock-out generation may share the one counter together.
// - Clock-out frequency is clock over four times the reload span.
// - Baud mode steps timer 2 every 2 clocks regardless of source select.
// - Clearing the timer 2 run bit stops it and keeps the count.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0CountIn,
  input wire logic timer1CountIn,
  input wire logic extIntPinZero,
  input wire logic extIntPinOne,
  input wire logic timer2TriggerPin,
  output logic port1Bit0,
  output logic port1Bit0Oe,
  output logic timer1Overflow,
  output logic timer0Irq,
  output logic timer1Irq,
  output logic timer2Irq
);
  tmc_t2_if t2 ();

  logic [7:0] timerMode, next_timerMode;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] tl0, next_tl0;
  logic [7:0] th0, next_th0;
  logic [7:0] tl1, next_tl1;
  logic [7:0] th1, next_th1;
  logic [7:0] t2ctrl, next_t2ctrl;
  logic [7:0] relLo, next_relLo;
  logic [7:0] relHi, next_relHi;
  logic [7:0] t2opt, next_t2opt;
  logic [7:0] clkSel, next_clkSel;
  logic [3:0] preCnt, next_preCnt;
  logic t0Prev, next_t0Prev;
  logic t1Prev, next_t1Prev;
  logic t1Ovf, next_t1Ovf;
  logic [31:0] rdData, next_rdData;
  logic preTick, wr, mapped, t0Split, t0Run, t0Tick, t1Run, t1Tick, thRoll;
  logic [16:0] t0Step, t1Step;
  logic [7:0] rdVal;
  tmc_pkg::tmc_mode_e m0, m1;

  // one count step: {overflow, high byte, low byte}
  function automatic logic [16:0] tmcStep(input tmc_pkg::tmc_mode_e m, input logic [7:0] lo,
    input logic [7:0] hi);
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    case (m)
      tmc_pkg::MODE_13BIT: tmcStep = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
      tmc_pkg::MODE_16BIT: tmcStep = {&{hi, lo}, c16};
      tmc_pkg::MODE_RELOAD8: tmcStep = {&lo, hi, (&lo) ? hi : c16[7:0]};
      default: tmcStep = {&lo, hi, c16[7:0]};
    endcase
  endfunction : tmcStep

  function automatic logic isWr(input logic w, input logic [7:0] a, input logic [7:0] ofs);
    isWr = w && (a == ofs);
  endfunction : isWr

  always_comb
  begin
    m0 = tmc_pkg::tmc_mode_e'(timerMode[1:0]);
    m1 = tmc_pkg::tmc_mode_e'(timerMode[tmc_pkg::T1_NIB +: 2]);
    t0Split = (m0 == tmc_pkg::MODE_SPLIT);
    preTick = (preCnt == 4'h0);
    wr = psel && penable && pwrite;
    // timer 0 (or its low byte in split mode) keeps its own controls
    t0Tick = timerMode[tmc_pkg::MODE_CT] ? (t0Prev & ~timer0CountIn) : preTick;
    t0Run = ctrl[tmc_pkg::CTRL_T0RUN]
      && (!timerMode[tmc_pkg::MODE_GATE] || extIntPinZero);
    t1Tick = timerMode[tmc_pkg::T1_NIB + tmc_pkg::MODE_CT] ? (t1Prev & ~timer1CountIn) : preTick;
    // with timer 0 split, only its own mode 3 or a closed gate stops timer 1
    t1Run = (t0Split || ctrl[tmc_pkg::CTRL_T1RUN])
      && (!timerMode[tmc_pkg::T1_NIB + tmc_pkg::MODE_GATE] || extIntPinOne)
      && (m1 != tmc_pkg::MODE_SPLIT);
    t0Step = tmcStep(m0, tl0, th0);
    t1Step = tmcStep(m1, tl1, th1);
    thRoll = t0Split && ctrl[tmc_pkg::CTRL_T1RUN] && preTick && (th0 == 8'hFF);
  end

  always_comb
  begin
    next_preCnt = preTick
      ? (clkSel[tmc_pkg::CLKSEL_FAST] ? tmc_pkg::DIV_FAST : tmc_pkg::DIV_SLOW) - 4'h1
      : preCnt - 4'h1;
    next_t0Prev = timer0CountIn;
    next_t1Prev = timer1CountIn;
    next_timerMode = isWr(wr, paddr, tmc_pkg::OFS_MODE) ? pwdata[7:0] : timerMode;
    next_ctrl = isWr(wr, paddr, tmc_pkg::OFS_CTRL) ? pwdata[7:0] : ctrl;
    next_t2ctrl = isWr(wr, paddr, tmc_pkg::OFS_T2CTRL) ? pwdata[7:0] : t2ctrl;
    next_relLo = isWr(wr, paddr, tmc_pkg::OFS_RELLO) ? pwdata[7:0] : relLo;
    next_relHi = isWr(wr, paddr, tmc_pkg::OFS_RELHI) ? pwdata[7:0] : relHi;
    next_t2opt = isWr(wr, paddr, tmc_pkg::OFS_T2OPT) ? pwdata[7:0] : t2opt;
    next_clkSel = isWr(wr, paddr, tmc_pkg::OFS_CLKSEL) ? pwdata[7:0] : clkSel;
    next_tl0 = tl0;
    next_th0 = th0;
    next_tl1 = tl1;
    next_th1 = th1;
    next_t1Ovf = 1'b0;
    if (t0Run && t0Tick)
    begin
      next_tl0 = t0Step[7:0];
      next_th0 = t0Split ? th0 : t0Step[15:8];
      // hardware set wins over a same-cycle software clear
      if (t0Step[16])
      begin
        next_ctrl[tmc_pkg::CTRL_T0OVF] = 1'b1;
      end
    end
    if (thRoll || (t0Split && ctrl[tmc_pkg::CTRL_T1RUN] && preTick))
    begin
      next_th0 = th0 + 8'h01;
    end
    if (thRoll)
    begin
      next_ctrl[tmc_pkg::CTRL_T1OVF] = 1'b1;
    end
    if (t1Run && t1Tick)
    begin
      next_tl1 = t1Step[7:0];
      next_th1 = t1Step[15:8];
      next_t1Ovf = t1Step[16];
      if (t1Step[16] && !t0Split)
      begin
        next_ctrl[tmc_pkg::CTRL_T1OVF] = 1'b1;
      end
    end
    if (t2.setOvf)
    begin
      next_t2ctrl[tmc_pkg::T2_OVF] = 1'b1;
    end
    if (t2.setExtFlag)
    begin
      next_t2ctrl[tmc_pkg::T2_EXTF] = 1'b1;
    end
    if (isWr(wr, paddr, tmc_pkg::OFS_T0LO))
    begin
      next_tl0 = pwdata[7:0];
    end
    if (isWr(wr, paddr, tmc_pkg::OFS_T0HI))
    begin
      next_th0 = pwdata[7:0];
    end
    if (isWr(wr, paddr, tmc_pkg::OFS_T1LO))
    begin
      next_tl1 = pwdata[7:0];
    end
    if (isWr(wr, paddr, tmc_pkg::OFS_T1HI))
    begin
      next_th1 = pwdata[7:0];
    end
  end

  // read data is latched in the setup phase so prdata comes from a flop
  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      tmc_pkg::OFS_MODE: rdVal = timerMode;
      tmc_pkg::OFS_CTRL: rdVal = ctrl;
      tmc_pkg::OFS_T0LO: rdVal = tl0;
      tmc_pkg::OFS_T0HI: rdVal = th0;
      tmc_pkg::OFS_T1LO: rdVal = tl1;
      tmc_pkg::OFS_T1HI: rdVal = th1;
      tmc_pkg::OFS_T2CTRL: rdVal = t2ctrl;
      tmc_pkg::OFS_T2LO: rdVal = t2.count[7:0];
      tmc_pkg::OFS_T2HI: rdVal = t2.count[15:8];
      tmc_pkg::OFS_RELLO: rdVal = relLo;
      tmc_pkg::OFS_RELHI: rdVal = relHi;
      tmc_pkg::OFS_T2OPT: rdVal = t2opt;
      tmc_pkg::OFS_CLKSEL: rdVal = clkSel;
      default:
      begin
        rdVal = 8'h00;
        mapped = 1'b0;
      end
    endcase
    next_rdData = (psel && !penable) ? {24'h000000, rdVal} : rdData;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timerMode <= tmc_pkg::RST_BYTE;
      ctrl <= tmc_pkg::RST_BYTE;
      tl0 <= tmc_pkg::RST_BYTE;
      th0 <= tmc_pkg::RST_BYTE;
      tl1 <= tmc_pkg::RST_BYTE;
      th1 <= tmc_pkg::RST_BYTE;
      t2ctrl <= tmc_pkg::RST_BYTE;
      relLo <= tmc_pkg::RST_BYTE;
      relHi <= tmc_pkg::RST_BYTE;
      t2opt <= tmc_pkg::RST_BYTE;
      clkSel <= tmc_pkg::RST_BYTE;
      preCnt <= 4'h0;
      t0Prev <= 1'b1;
      t1Prev <= 1'b1;
      t1Ovf <= 1'b0;
      rdData <= 32'h00000000;
    end
    else
    begin
      timerMode <= next_timerMode;
      ctrl <= next_ctrl;
      tl0 <= next_tl0;
      th0 <= next_th0;
      tl1 <= next_tl1;
      th1 <= next_th1;
      t2ctrl <= next_t2ctrl;
      relLo <= next_relLo;
      relHi <= next_relHi;
      t2opt <= next_t2opt;
      clkSel <= next_clkSel;
      preCnt <= next_preCnt;
      t0Prev <= next_t0Prev;
      t1Prev <= next_t1Prev;
      t1Ovf <= next_t1Ovf;
      rdData <= next_rdData;
    end
  end

  assign t2.preTick = preTick;
  assign t2.run = t2ctrl[tmc_pkg::T2_RUN];
  assign t2.baudMode = t2ctrl[tmc_pkg::T2_RXSRC] | t2ctrl[tmc_pkg::T2_TXSRC];
  // clock-out needs timer source and auto-reload selected as well
  assign t2.clkOutMode = t2opt[tmc_pkg::OPT_CLKOE] && !t2ctrl[tmc_pkg::T2_CSRC]
    && !t2ctrl[tmc_pkg::T2_CPRL];
  assign t2.trigEn = t2ctrl[tmc_pkg::T2_EXTEN];
  assign t2.trigPin = timer2TriggerPin;
  assign t2.reload = {relHi, relLo};
  assign t2.wrLo = isWr(wr, paddr, tmc_pkg::OFS_T2LO);
  assign t2.wrHi = isWr(wr, paddr, tmc_pkg::OFS_T2HI);
  assign t2.wrData = pwdata[7:0];

  tmc_timer2 u_timer2 (
    .clk(clk),
    .rst(rst),
    .t2(t2)
  );

  assign prdata = rdData;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign port1Bit0 = t2.clkOut;
  assign port1Bit0Oe = t2.clkOutMode;
  assign timer1Overflow = t1Ovf;
  assign timer0Irq = ctrl[tmc_pkg::CTRL_T0OVF];
  assign timer1Irq = ctrl[tmc_pkg::CTRL_T1OVF];
  assign timer2Irq = t2ctrl[tmc_pkg::T2_OVF] | t2ctrl[tmc_pkg::T2_EXTF];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_T1_FROZEN: assert property (m1 == tmc_pkg::MODE_SPLIT && !wr |=> $stable({th1, tl1}))
    else $error("timer 1 moved in mode 3");
  AST_T0_HI_COUNT: assert property (t0Split && ctrl[tmc_pkg::CTRL_T1RUN] && preTick && !wr
    |=> th0 == $past(th0) + 8'h01)
    else $error("split high byte did not count");
  AST_T0_HI_FLAG: assert property (thRoll |=> ctrl[tmc_pkg::CTRL_T1OVF])
    else $error("split high byte rollover did not set timer 1 flag");
  AST_T0_LO_STOP: assert property (t0Split && !ctrl[tmc_pkg::CTRL_T0RUN] && !wr
    |=> $stable(tl0))
    else $error("split low byte counted without its run bit");
  AST_T0_LO_ONLY: assert property (t0Split && t0Run && t0Tick && !ctrl[tmc_pkg::CTRL_T1RUN]
    && !wr |=> $stable(th0) && tl0 == $past(tl0) + 8'h01)
    else $error("split bytes not independent");
  AST_T1_NO_FLAG: assert property (t0Split && !ctrl[tmc_pkg::CTRL_T1OVF] && !thRoll && !wr
    |=> !ctrl[tmc_pkg::CTRL_T1OVF])
    else $error("timer 1 drove its flag while timer 0 split");
  AST_PRESCALE_FAST: assert property (preTick && clkSel[tmc_pkg::CLKSEL_FAST]
    && !wr |=> !preTick [*3] ##1 preTick)
    else $error("fast prescale not 4 clocks");
  COV_SPLIT_HI_ROLL: cover property (thRoll);
  COV_T1_BAUD: cover property (t0Split && t1Ovf);
endmodule : tmc_timer_top
`default_nettype wire

// ===== tmc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_far_side (
  input wire logic clk,
  output logic count0,
  output logic count1,
  output logic pin0,
  output logic pin1,
  output logic trig
);
  // idle high so that only commanded edges ever count
  initial
  begin
    count0 = 1'b1;
    count1 = 1'b1;
    pin0 = 1'b1;
    pin1 = 1'b1;
    trig = 1'b1;
  end

  // w sets how slowly the far side moves its count pin
  task automatic fall0(input int n, input int w);
    repeat (n)
    begin
      @(posedge clk);
      count0 <= 1'b0;
      repeat (w) @(posedge clk);
      count0 <= 1'b1;
      repeat (w) @(posedge clk);
    end
  endtask : fall0

  task automatic gates(input logic g0, input logic g1);
    @(posedge clk);
    pin0 <= g0;
    pin1 <= g1;
    repeat (2) @(posedge clk);
  endtask : gates

  task automatic trigFall();
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
    trig <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : trigFall
endmodule : tmc_far_side
`default_nettype wire

// ===== tmc_timer_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_top_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, errFlag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, q2, v;
  logic cnt0, cnt1, pin0, pin1, trig, p10, p10Oe, t1Ovf, irq0, irq1, irq2;
  int nFail = 0;
  int checksDone = 0;
  int t1Pulses = 0;
  int h, p, s;

  tmc_timer_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0CountIn(cnt0), .timer1CountIn(cnt1), .extIntPinZero(pin0), .extIntPinOne(pin1),
    .timer2TriggerPin(trig), .port1Bit0(p10), .port1Bit0Oe(p10Oe), .timer1Overflow(t1Ovf),
    .timer0Irq(irq0), .timer1Irq(irq1), .timer2Irq(irq2));
  tmc_far_side far (.clk(clk), .count0(cnt0), .count1(cnt1), .pin0(pin0), .pin1(pin1),
    .trig(trig));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
    if (t1Ovf === 1'b1) t1Pulses <= t1Pulses + 1;

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checksDone++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      nFail++;
      $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk

  // one idle edge after each transfer keeps psel from being assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0);
    chk(q, lo, hi);
  endtask : rc

  task automatic rd2(input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, tmc_pkg::OFS_T2LO, 32'h0);
    q2 = q;
    apb(1'b0, tmc_pkg::OFS_T2HI, 32'h0);
    chk({16'h0000, q[7:0], q2[7:0]}, lo, hi);
  endtask : rd2

  // high time and full period of the clock-out pin, in clocks
  task automatic per();
    int n;
    n = 0;
    while (p10 !== 1'b0 && n < 500) begin @(posedge clk); n++; end
    while (p10 !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    h = 0;
    while (p10 === 1'b1 && h < 500) begin @(posedge clk); h++; end
    p = h;
    while (p10 === 1'b0 && p < 1000) begin @(posedge clk); p++; end
  endtask : per

  initial
  begin
    repeat (20000) @(posedge clk);
    nFail++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(tmc_pkg::OFS_MODE, 32'h0, 32'h0);
    rc(tmc_pkg::OFS_T2CTRL, 32'h0, 32'h0);
    rc(8'h3C, 32'h0, 32'h0);
    chk(32'(errFlag), 32'h1, 32'h1);
    $display("test reset done");
    // split timer 0, fast prescale: 43 enabled edges give 10 or 11 ticks
    wr(tmc_pkg::OFS_CLKSEL, 32'h1);
    wr(tmc_pkg::OFS_MODE, 32'h03);
    wr(tmc_pkg::OFS_CTRL, 32'h10);
    repeat (40) @(posedge clk);
    wr(tmc_pkg::OFS_CTRL, 32'h0);
    rc(tmc_pkg::OFS_T0LO, 32'h09, 32'h0C);
    v = q;
    rc(tmc_pkg::OFS_T0HI, 32'h0, 32'h0);
    wr(tmc_pkg::OFS_T0HI, 32'hFF);
    wr(tmc_pkg::OFS_CTRL, 32'h40);
    repeat (40) @(posedge clk);
    // flag read while running: writing the control byte would overwrite it
    rc(tmc_pkg::OFS_CTRL, 32'hC0, 32'hC0);
    chk(32'({irq1, irq0}), 32'h2, 32'h2);
    wr(tmc_pkg::OFS_CTRL, 32'h0);
    rc(tmc_pkg::OFS_T0HI, 32'h08, 32'h0B);
    rc(tmc_pkg::OFS_T0LO, v, v);
    // low byte as event counter, then gated by pin zero
    wr(tmc_pkg::OFS_T0LO, 32'h0);
    wr(tmc_pkg::OFS_MODE, 32'h07);
    wr(tmc_pkg::OFS_CTRL, 32'h10);
    far.fall0(5, 2);
    rc(tmc_pkg::OFS_T0LO, 32'h5, 32'h5);
    wr(tmc_pkg::OFS_MODE, 32'h0F);
    far.gates(1'b0, 1'b0);
    far.fall0(3, 1);
    rc(tmc_pkg::OFS_T0LO, 32'h5, 32'h5);
    far.gates(1'b1, 1'b0);
    far.fall0(3, 4);
    rc(tmc_pkg::OFS_T0LO, 32'h8, 32'h8);
    wr(tmc_pkg::OFS_CTRL, 32'h0);
    $display("test split timer 0 done");
    // timer 1 beside split timer 0: run bit ignored, gate honoured
    // gate closed first, else the split timer 1 counts between the writes
    wr(tmc_pkg::OFS_MODE, 32'h93);
    wr(tmc_pkg::OFS_T1LO, 32'h0);
    wr(tmc_pkg::OFS_T1HI, 32'h0);
    repeat (40) @(posedge clk);
    rc(tmc_pkg::OFS_T1LO, 32'h0, 32'h0);
    far.gates(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    rc(tmc_pkg::OFS_T1LO, 32'h08, 32'h0C);
    wr(tmc_pkg::OFS_MODE, 32'h33);
    apb(1'b0, tmc_pkg::OFS_T1LO, 32'h0);
    v = q;
    repeat (40) @(posedge clk);
    rc(tmc_pkg::OFS_T1LO, v, v);
    wr(tmc_pkg::OFS_MODE, 32'h13);
    repeat (40) @(posedge clk);
    rc(tmc_pkg::OFS_T1LO, v + 8, v + 12);
    s = t1Pulses;
    wr(tmc_pkg::OFS_T1HI, 32'hFF);
    wr(tmc_pkg::OFS_T1LO, 32'hF0);
    repeat (100) @(posedge clk);
    chk(t1Pulses - s, 32'h1, 32'h1);
    wr(tmc_pkg::OFS_MODE, 32'h0);
    $display("test timer 1 done");
    // baud mode from each source bit; 106 enabled edges give 53 steps of 2 clocks
    wr(tmc_pkg::OFS_RELLO, 32'hF0);
    wr(tmc_pkg::OFS_RELHI, 32'hFF);
    for (int i = 0; i < 2; i++)
    begin
      wr(tmc_pkg::OFS_T2LO, 32'hF0);
      wr(tmc_pkg::OFS_T2HI, 32'hFF);
      wr(tmc_pkg::OFS_T2CTRL, (i == 0) ? 32'h26 : 32'h16);
      repeat (100) @(posedge clk);
      // overflow flag checked still clear before the stop write would clear it
      rc(tmc_pkg::OFS_T2CTRL, (i == 0) ? 32'h26 : 32'h16, (i == 0) ? 32'h26 : 32'h16);
      wr(tmc_pkg::OFS_T2CTRL, 32'h0);
      rd2(32'hFFF2, 32'hFFF5);
      v = q2;
      repeat (20) @(posedge clk);
      rc(tmc_pkg::OFS_T2LO, v, v);
    end
    wr(tmc_pkg::OFS_T2CTRL, 32'h20);
    far.trigFall();
    rc(tmc_pkg::OFS_T2CTRL, 32'h20, 32'h20);
    wr(tmc_pkg::OFS_T2CTRL, 32'h28);
    far.trigFall();
    rc(tmc_pkg::OFS_T2CTRL, 32'h68, 32'h68);
    chk(32'(irq2), 32'h1, 32'h1);
    wr(tmc_pkg::OFS_T2CTRL, 32'h0);
    $display("test baud mode done");
    // clock-out: software sets enable with both selects clear
    wr(tmc_pkg::OFS_T2LO, 32'hF0);
    wr(tmc_pkg::OFS_T2HI, 32'hFF);
    wr(tmc_pkg::OFS_T2OPT, 32'h1);
    repeat (100) @(posedge clk);
    chk(32'({p10Oe, p10}), 32'h2, 32'h2);
    rd2(32'hFFF0, 32'hFFF0);
    wr(tmc_pkg::OFS_T2CTRL, 32'h04);
    per();
    chk(h, 32, 32);
    chk(p, 64, 64);
    rc(tmc_pkg::OFS_T2CTRL, 32'h04, 32'h04);
    chk(32'(irq2), 32'h0, 32'h0);
    wr(tmc_pkg::OFS_T2CTRL, 32'h34);
    per();
    chk(p, 64, 64);
    chk(32'(irq2), 32'h0, 32'h0);
    wr(tmc_pkg::OFS_T2CTRL, 32'h0);
    $display("test clock-out done");
    finish_test();
  end
endmodule : tmc_timer_top_tb
`default_nettype wire
